/* File: hw/gpib_bridge_pkg.sv */
package gpib_bridge_pkg;

    typedef enum logic [1:0] {ST_IDLE, ST_TALK, ST_LISTEN, ST_SPOLL} bus_state_t;
    typedef enum logic [2:0] {CY_IDLE, CY_LEAD, CY_S1, CY_GAP, CY_S2, CY_TAIL} cyc_phase_t;
    typedef enum logic [2:0] {
        LS_FIRST, LS_ADDR, LS_STATION, LS_W_LO, LS_W_MID, LS_W_HI, LS_DONE
    } lseq_t;

    // Interface commands (low seven data bits, ATN true)
    localparam logic [6:0] CMD_UNL = 7'h3F;
    localparam logic [6:0] CMD_UNT = 7'h5F;
    localparam logic [6:0] CMD_SPE = 7'h18;
    localparam logic [6:0] CMD_SPD = 7'h19;
    localparam logic [1:0] GRP_LISTEN = 2'h1;
    localparam logic [1:0] GRP_TALK = 2'h2;

    // First listen byte class, taken from data bits 5 and 6
    localparam logic [1:0] CLS_SETUP = 2'h0;
    localparam logic [1:0] CLS_GLOBAL = 2'h1;

    // Setup byte fields
    localparam int SET_NB_LSB = 0;
    localparam int SET_BLOCK_BIT = 2;
    localparam int SET_SRQ_LSB = 3;
    // Global byte fields
    localparam int GLB_C_BIT = 0;
    localparam int GLB_Z_BIT = 1;
    localparam int GLB_I_BIT = 2;
    // Status byte fields
    localparam int SB_X_BIT = 0;
    localparam int SB_Q_BIT = 1;
    localparam int SB_SRQ_BIT = 6;
    localparam logic [1:0] MAX_BYTES = 2'h3;

    // APB register byte offsets
    localparam logic [11:0] OFF_CFG = 12'h000;
    localparam logic [11:0] OFF_STATUS = 12'h004;
    localparam logic [11:0] OFF_CMD = 12'h008;
    localparam logic [11:0] OFF_RDATA = 12'h00C;
    localparam logic [11:0] OFF_WDATA = 12'h010;

    // Dataway and talker timing
    localparam int CLK_PERIOD_PS = 5000;
    localparam int LEAD_NS = 500;
    localparam int STROBE_NS = 250;
    localparam int GAP_NS = 125;
    localparam int DAV_DLY_NS = 200;
    localparam int CNT_W = 7;
    localparam logic [CNT_W-1:0] LEAD_CYC =
        CNT_W'((LEAD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    localparam logic [CNT_W-1:0] STROBE_CYC =
        CNT_W'((STROBE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    localparam logic [CNT_W-1:0] GAP_CYC =
        CNT_W'((GAP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    localparam logic [CNT_W-1:0] DAV_DLY_CYC =
        CNT_W'((DAV_DLY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    localparam logic [CNT_W-1:0] CNT_ONE = 7'h01;

    typedef struct packed {
        bus_state_t st;
        logic sp_talk;
        logic acc_hold;
        lseq_t lseq;
        logic [4:0] fn;
        logic [3:0] sa;
        logic [4:0] stn;
        logic [23:0] wd;
        logic gc;
        logic gz;
        logic gi;
        logic [1:0] nb_code;
        logic blk;
        logic [1:0] srq_cond;
        logic srq;
        cyc_phase_t ph;
        logic [CNT_W-1:0] cnt;
        logic [23:0] rd;
        logic xr;
        logic qr;
        logic rd_valid;
        logic dav;
        logic [CNT_W-1:0] dly;
        logic [1:0] bidx;
        logic src_done;
        logic [7:0] dout;
        logic eoi;
        logic [4:0] own_addr;
        logic [31:0] prdata;
    } core_t;

endpackage : gpib_bridge_pkg

/* File: hw/gpib_camac_bridge_control.sv */
`timescale 1ns/100ps
module gpib_camac_bridge_control
    import gpib_bridge_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic ifc_i,
    input wire logic atn_i,
    input wire logic [7:0] dio_i,
    output logic [7:0] dio_o,
    output logic dio_oe_n_o,
    input wire logic dav_i,
    output logic dav_o,
    input wire logic rfd_i,
    output logic rfd_o,
    input wire logic dac_i,
    output logic dac_o,
    output logic eoi_o,
    output logic srq_o,
    output logic busy_o,
    output logic drv_en_o,
    output logic s1_o,
    output logic s2_o,
    output logic [4:0] f_o,
    output logic [3:0] a_o,
    output logic [4:0] n_o,
    output logic [23:0] w_o,
    output logic c_o,
    output logic z_o,
    output logic i_o,
    input wire logic [23:0] r_i,
    input wire logic x_i,
    input wire logic q_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o
);

    core_t s_ff;
    core_t nxt_s;
    logic acc_en;
    logic take;
    logic cmd_take;
    logic [6:0] cmd;
    logic is_mta;
    logic is_mla;
    logic talk_act;

    function automatic logic own_cmd(input logic [6:0] c, input logic [1:0] grp,
                                     input logic [4:0] addr);
        own_cmd = (c[6:5] == grp) && (c[4:0] == addr);
    endfunction : own_cmd

    function automatic logic [1:0] data_bytes(input logic [1:0] code);
        data_bytes = MAX_BYTES - code;
    endfunction : data_bytes

    function automatic logic [7:0] read_byte(input logic [23:0] d, input logic [1:0] idx);
        read_byte = d[{3'h0, idx} * 5'h08 +: 8];
    endfunction : read_byte

    function automatic logic [7:0] xq_byte(input logic x, input logic q);
        xq_byte = 8'h00;
        xq_byte[SB_X_BIT] = x;
        xq_byte[SB_Q_BIT] = q;
    endfunction : xq_byte

    assign cmd = dio_i[6:0];
    assign acc_en = atn_i || (s_ff.st == ST_LISTEN);
    assign take = acc_en && !s_ff.acc_hold && dav_i;
    assign cmd_take = take && atn_i;
    assign is_mta = own_cmd(cmd, GRP_TALK, s_ff.own_addr);
    assign is_mla = own_cmd(cmd, GRP_LISTEN, s_ff.own_addr);
    assign talk_act = !atn_i &&
        ((s_ff.st == ST_TALK) || ((s_ff.st == ST_SPOLL) && s_ff.sp_talk));

    always_comb begin
        logic start;
        logic srq_set;
        logic [1:0] nb;
        logic src_ok;
        start = 1'b0;
        srq_set = 1'b0;
        nb = data_bytes(s_ff.nb_code);
        src_ok = 1'b0;
        nxt_s = s_ff;

        // Acceptor handshake
        if (take) begin
            nxt_s.acc_hold = 1'b1;
        end else if (s_ff.acc_hold && !dav_i) begin
            nxt_s.acc_hold = 1'b0;
        end

        if (cmd_take) begin
            if (cmd == CMD_SPE) begin
                nxt_s.st = ST_SPOLL;
                nxt_s.sp_talk = 1'b0;
            end else if (cmd == CMD_SPD) begin
                if (s_ff.st == ST_SPOLL) begin
                    nxt_s.st = ST_IDLE;
                end
                nxt_s.sp_talk = 1'b0;
                nxt_s.srq = 1'b0;
            end else if (is_mta) begin
                if (s_ff.st == ST_SPOLL) begin
                    nxt_s.sp_talk = 1'b1;
                    nxt_s.src_done = 1'b0;
                end else begin
                    nxt_s.st = ST_TALK;
                    nxt_s.bidx = 2'h0;
                    nxt_s.src_done = 1'b0;
                    start = 1'b1;
                end
            end else if (is_mla) begin
                nxt_s.st = ST_LISTEN;
                nxt_s.lseq = LS_FIRST;
            end else if (cmd == CMD_UNL) begin
                if (s_ff.st == ST_LISTEN) begin
                    nxt_s.st = ST_IDLE;
                end
            end else if (cmd == CMD_UNT) begin
                if (s_ff.st == ST_TALK) begin
                    nxt_s.st = ST_IDLE;
                end
                nxt_s.sp_talk = 1'b0;
            end
            // Other commands fall through untouched
        end

        // Listener bytes
        if (take && !atn_i && (s_ff.st == ST_LISTEN)) begin
            case (s_ff.lseq)
                LS_FIRST: begin
                    if (dio_i[6:5] == CLS_SETUP) begin
                        nxt_s.nb_code = dio_i[SET_NB_LSB +: 2];
                        nxt_s.blk = dio_i[SET_BLOCK_BIT];
                        nxt_s.srq_cond = dio_i[SET_SRQ_LSB +: 2];
                        nxt_s.lseq = LS_DONE;
                    end else if (dio_i[6:5] == CLS_GLOBAL) begin
                        nxt_s.gc = dio_i[GLB_C_BIT];
                        nxt_s.gz = dio_i[GLB_Z_BIT];
                        nxt_s.gi = dio_i[GLB_I_BIT];
                        nxt_s.lseq = LS_DONE;
                    end else begin
                        nxt_s.fn = dio_i[4:0];
                        nxt_s.lseq = LS_ADDR;
                    end
                end
                LS_ADDR: begin
                    nxt_s.sa = dio_i[3:0];
                    nxt_s.lseq = LS_STATION;
                end
                LS_STATION: begin
                    nxt_s.stn = dio_i[4:0];
                    nxt_s.lseq = LS_W_LO;
                end
                LS_W_LO: begin
                    nxt_s.wd[7:0] = dio_i;
                    nxt_s.lseq = LS_W_MID;
                end
                LS_W_MID: begin
                    nxt_s.wd[15:8] = dio_i;
                    nxt_s.lseq = LS_W_HI;
                end
                LS_W_HI: begin
                    nxt_s.wd[23:16] = dio_i;
                    nxt_s.lseq = LS_DONE;
                end
                default: begin
                    nxt_s.lseq = LS_DONE;
                end
            endcase
        end

        // Source handshake
        src_ok = talk_act && !s_ff.src_done &&
            ((s_ff.st == ST_SPOLL) || (s_ff.rd_valid && (s_ff.ph == CY_IDLE)));
        if (!talk_act) begin
            nxt_s.dav = 1'b0;
            nxt_s.dly = '0;
        end else if (!s_ff.dav) begin
            if (s_ff.st == ST_SPOLL) begin
                nxt_s.dout = xq_byte(s_ff.xr, s_ff.qr);
                nxt_s.dout[SB_SRQ_BIT] = s_ff.srq;
                nxt_s.eoi = 1'b1;
            end else if (s_ff.bidx < nb) begin
                nxt_s.dout = read_byte(s_ff.rd, s_ff.bidx);
                nxt_s.eoi = 1'b0;
            end else begin
                nxt_s.dout = xq_byte(s_ff.xr, s_ff.qr);
                nxt_s.eoi = 1'b1;
            end
            if (src_ok && rfd_i) begin
                if (s_ff.dly == DAV_DLY_CYC - CNT_ONE) begin
                    nxt_s.dav = 1'b1;
                end else begin
                    nxt_s.dly = s_ff.dly + CNT_ONE;
                end
            end else begin
                nxt_s.dly = '0;
            end
        end else if (dac_i) begin
            nxt_s.dav = 1'b0;
            nxt_s.dly = '0;
            if (s_ff.st == ST_SPOLL) begin
                nxt_s.src_done = 1'b1;
                nxt_s.srq = 1'b0;
            end else if (s_ff.bidx < nb) begin
                if ((s_ff.bidx == nb - 2'h1) && s_ff.blk) begin
                    nxt_s.bidx = 2'h0;
                    start = 1'b1;
                end else begin
                    nxt_s.bidx = s_ff.bidx + 2'h1;
                end
            end else begin
                nxt_s.src_done = 1'b1;
            end
        end

        // Dataway cycle sequencer
        case (s_ff.ph)
            CY_IDLE: begin
                if (start) begin
                    nxt_s.ph = CY_LEAD;
                    nxt_s.cnt = '0;
                    nxt_s.rd_valid = 1'b0;
                end
            end
            CY_LEAD: begin
                nxt_s.cnt = s_ff.cnt + CNT_ONE;
                if (s_ff.cnt == LEAD_CYC - CNT_ONE) begin
                    nxt_s.ph = CY_S1;
                    nxt_s.cnt = '0;
                end
            end
            CY_S1: begin
                nxt_s.cnt = s_ff.cnt + CNT_ONE;
                if (s_ff.cnt == STROBE_CYC - CNT_ONE) begin
                    nxt_s.ph = CY_GAP;
                    nxt_s.cnt = '0;
                    nxt_s.rd = r_i;
                    nxt_s.xr = x_i;
                    nxt_s.qr = q_i;
                    nxt_s.rd_valid = 1'b1;
                    if (!q_i) begin
                        nxt_s.blk = 1'b0;
                    end
                    srq_set = (s_ff.srq_cond[0] && !x_i) || (s_ff.srq_cond[1] && q_i);
                end
            end
            CY_GAP: begin
                nxt_s.cnt = s_ff.cnt + CNT_ONE;
                if (s_ff.cnt == GAP_CYC - CNT_ONE) begin
                    nxt_s.ph = CY_S2;
                    nxt_s.cnt = '0;
                end
            end
            CY_S2: begin
                nxt_s.cnt = s_ff.cnt + CNT_ONE;
                if (s_ff.cnt == STROBE_CYC - CNT_ONE) begin
                    nxt_s.ph = CY_TAIL;
                    nxt_s.cnt = '0;
                end
            end
            CY_TAIL: begin
                nxt_s.cnt = s_ff.cnt + CNT_ONE;
                if (s_ff.cnt == GAP_CYC - CNT_ONE) begin
                    nxt_s.ph = CY_IDLE;
                    nxt_s.cnt = '0;
                    nxt_s.gc = 1'b0;
                    nxt_s.gz = 1'b0;
                end
            end
            default: begin
                nxt_s.ph = CY_IDLE;
            end
        endcase

        // A new request wins over an SPD or serial poll clear in the same cycle
        nxt_s.srq = nxt_s.srq | srq_set;

        // APB: read data captured in setup, write at access
        if (psel_i && !penable_i) begin
            case (paddr_i)
                OFF_CFG: nxt_s.prdata = {27'h0000000, s_ff.own_addr};
                OFF_STATUS: nxt_s.prdata = {20'h00000, s_ff.srq_cond, s_ff.nb_code,
                    s_ff.rd_valid, s_ff.qr, s_ff.xr, s_ff.srq, s_ff.blk,
                    (s_ff.ph != CY_IDLE), s_ff.st};
                OFF_CMD: nxt_s.prdata = {15'h0000, s_ff.gi, s_ff.gz, s_ff.gc,
                    s_ff.stn, s_ff.sa, s_ff.fn};
                OFF_RDATA: nxt_s.prdata = {8'h00, s_ff.rd};
                OFF_WDATA: nxt_s.prdata = {8'h00, s_ff.wd};
                default: nxt_s.prdata = 32'h00000000;
            endcase
        end
        if (psel_i && penable_i && pwrite_i && (paddr_i == OFF_CFG)) begin
            nxt_s.own_addr = pwdata_i[4:0];
        end

        if (ifc_i) begin
            nxt_s = '0;
            nxt_s.own_addr = (psel_i && penable_i && pwrite_i && (paddr_i == OFF_CFG)) ?
                pwdata_i[4:0] : s_ff.own_addr;
            nxt_s.prdata = nxt_s.prdata | s_ff.prdata;
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            s_ff <= '0;
        end else if (ce_i) begin
            s_ff <= nxt_s;
        end
    end

    assign rfd_o = acc_en && !s_ff.acc_hold;
    assign dac_o = s_ff.acc_hold;
    assign dio_o = s_ff.dout;
    assign dio_oe_n_o = !talk_act;
    assign dav_o = s_ff.dav;
    assign eoi_o = s_ff.eoi && s_ff.dav;
    assign srq_o = s_ff.srq;
    assign busy_o = (s_ff.ph != CY_IDLE);
    assign drv_en_o = busy_o;
    assign s1_o = (s_ff.ph == CY_S1);
    assign s2_o = (s_ff.ph == CY_S2);
    assign f_o = busy_o ? s_ff.fn : 5'h00;
    assign a_o = busy_o ? s_ff.sa : 4'h0;
    assign n_o = busy_o ? s_ff.stn : 5'h00;
    assign w_o = busy_o ? s_ff.wd : 24'h000000;
    assign c_o = busy_o && s_ff.gc;
    assign z_o = busy_o && s_ff.gz;
    assign i_o = busy_o && s_ff.gi;
    assign prdata_o = s_ff.prdata;
    assign pready_o = psel_i && penable_i && ce_i;
    assign pslverr_o = pready_o && (paddr_i != OFF_CFG) && (paddr_i != OFF_STATUS) &&
        (paddr_i != OFF_CMD) && (paddr_i != OFF_RDATA) && (paddr_i != OFF_WDATA);

    // Strobe width counters for checking only
    logic [CNT_W-1:0] s1_len_ff;
    logic [CNT_W-1:0] s2_len_ff;
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            s1_len_ff <= '0;
            s2_len_ff <= '0;
        end else if (ce_i) begin
            s1_len_ff <= s1_o ? s1_len_ff + CNT_ONE : '0;
            s2_len_ff <= s2_o ? s2_len_ff + CNT_ONE : '0;
        end
    end

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);

    sequence seq_s1_done;
        $fell(s1_o);
    endsequence
    sequence seq_cycle_start;
        $rose(busy_o);
    endsequence

    chk_ifc_idle: assert property (ce_i && ifc_i |=> s_ff.st == ST_IDLE && !busy_o && !s_ff.blk)
        else $error("interface clear did not idle");
    chk_spe_enter: assert property (ce_i && !ifc_i && cmd_take && cmd == CMD_SPE
        |=> s_ff.st == ST_SPOLL)
        else $error("serial poll enable ignored");
    chk_unl_other: assert property (ce_i && !ifc_i && cmd_take && cmd == CMD_UNL &&
        s_ff.st != ST_LISTEN |=> s_ff.st == $past(s_ff.st))
        else $error("unlisten changed state outside listen");
    chk_mta_cycle: assert property (ce_i && !ifc_i && cmd_take && is_mta &&
        s_ff.st != ST_SPOLL && !busy_o |=> busy_o && s_ff.st == ST_TALK)
        else $error("talk address did not start cycle");
    chk_spoll_nocyc: assert property (s_ff.st == ST_SPOLL && !busy_o |=> !busy_o)
        else $error("cycle started in serial poll");
    chk_lead_time: assert property (seq_cycle_start |-> !s1_o [*8])
        else $error("S1 too early");
    chk_s1_width: assert property (seq_s1_done |-> s1_len_ff == STROBE_CYC)
        else $error("S1 width wrong");
    chk_s2_width: assert property ($fell(s2_o) |-> s2_len_ff == STROBE_CYC)
        else $error("S2 width wrong");
    chk_cz_cleared: assert property ($fell(busy_o) |-> !s_ff.gc && !s_ff.gz)
        else $error("clear or initialize latch survived cycle");
    chk_blk_q0: assert property (seq_s1_done and (!s_ff.qr) |-> !s_ff.blk)
        else $error("block flag kept after Q zero");

endmodule : gpib_camac_bridge_control

/* File: verification/gpib_far_side_model.sv */
`timescale 1ns/100ps
module gpib_far_side_model
    import gpib_bridge_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic stall_i,
    input wire logic dav_i,
    input wire logic eoi_i,
    input wire logic [7:0] dio_i,
    input wire logic busy_i,
    input wire logic [23:0] rsp_r_i,
    input wire logic rsp_x_i,
    input wire logic rsp_q_i,
    output logic rfd_o,
    output logic dac_o,
    output logic [23:0] r_o,
    output logic x_o,
    output logic q_o
);
    logic [8:0] rx_q[$];
    // Listener taking talker bytes, not ready while stalled
    always @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rfd_o <= 1'b0;
            dac_o <= 1'b0;
        end else if (dav_i && rfd_o) begin
            rx_q.push_back({eoi_i, dio_i});
            rfd_o <= 1'b0;
            dac_o <= 1'b1;
        end else if (!dav_i && dac_o) begin
            dac_o <= 1'b0;
        end else if (!dav_i) begin
            rfd_o <= !stall_i;
        end
    end
    // Dataway answers only while busy, else toggling
    always @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            {r_o, x_o, q_o} <= 26'h0;
        end else if (busy_i) begin
            {r_o, x_o, q_o} <= {rsp_r_i, rsp_x_i, rsp_q_i};
        end else begin
            {r_o, x_o, q_o} <= ~{r_o, x_o, q_o};
        end
    end
endmodule : gpib_far_side_model

/* File: verification/gpib_camac_bridge_control_bench.sv */
`timescale 1ns/100ps
module gpib_camac_bridge_control_bench import gpib_bridge_pkg::*; ();
    logic ref_clk_i, rst_i, ifc_i, atn, dav, stall, er, psel, penable, pwrite;
    logic [7:0] dio_drv, dio_o, dio_bus;
    logic [11:0] paddr;
    logic [31:0] pwdata, rd, prdata_o;
    logic dio_oe_n_o, dav_o, rfd_o, dac_o, eoi_o, srq_o, busy_o, drv_en_o, s1_o, s2_o;
    logic c_o, z_o, i_o, pready_o, pslverr_o, rfd_m, dac_m, x_m, q_m, rsp_x, rsp_q;
    logic [4:0] f_o, n_o;
    logic [3:0] a_o;
    logic [23:0] w_o, r_m, rsp_r, snap_w;
    logic [17:0] snap;
    int err_count, compares, want;
    int bc = 0, ncyc = 0, s1at, s1n, s2at, s2n, blen;
    assign dio_bus = dio_oe_n_o ? dio_drv : dio_o;
    gpib_camac_bridge_control u_gpib_camac_bridge_control (.ref_clk_i, .rst_i,
        .ce_i(1'b1), .ifc_i, .atn_i(atn), .dio_i(dio_bus), .dio_o, .dio_oe_n_o,
        .dav_i(dav), .dav_o, .rfd_i(rfd_m), .rfd_o, .dac_i(dac_m), .dac_o, .eoi_o,
        .srq_o, .busy_o, .drv_en_o, .s1_o, .s2_o, .f_o, .a_o, .n_o, .w_o, .c_o, .z_o,
        .i_o, .r_i(r_m), .x_i(x_m), .q_i(q_m), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o, .pready_o,
        .pslverr_o);
    gpib_far_side_model u_gpib_far_side_model (.ref_clk_i, .rst_i, .stall_i(stall),
        .dav_i(dav_o), .eoi_i(eoi_o), .dio_i(dio_bus), .busy_i(busy_o),
        .rsp_r_i(rsp_r), .rsp_x_i(rsp_x), .rsp_q_i(rsp_q), .rfd_o(rfd_m),
        .dac_o(dac_m), .r_o(r_m), .x_o(x_m), .q_o(q_m));
    initial begin
        ref_clk_i = 1'b0;
        forever #2.5 ref_clk_i = ~ref_clk_i;
    end
    // Dataway cycle timing and driven command snapshot
    always @(posedge ref_clk_i) begin
        if (busy_o === 1'b1) begin
            if (bc == 0) begin
                ncyc <= ncyc + 1;
                s1n <= 0;
                s2n <= 0;
            end
            bc <= bc + 1;
            snap <= {i_o, z_o, c_o, n_o, a_o, f_o};
            snap_w <= w_o;
            if (s1_o === 1'b1) s1n <= s1n + 1;
            if (s1_o === 1'b1 && s1n == 0) s1at <= bc;
            if (s2_o === 1'b1) s2n <= s2n + 1;
            if (s2_o === 1'b1 && s2n == 0) s2at <= bc;
        end else if (bc != 0) begin
            blen <= bc;
            bc <= 0;
        end
    end
    task complete_run();
        if (err_count == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : complete_run
    task cmp(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp
    function logic pick(input int k);
        case (k)
            0: pick = rfd_o;
            1: pick = dac_o;
            2: pick = pready_o;
            default: pick = u_gpib_far_side_model.rx_q.size() >= want;
        endcase
    endfunction : pick
    task wait_on(input int k, input logic v);
        int n;
        n = 0;
        do begin
            @(posedge ref_clk_i);
            n++;
        end while (pick(k) !== v && n < 9000);
        if (n >= 9000) begin
            err_count++;
            $display("wrong value at %0t: wait ran out", $time);
            complete_run();
        end
    endtask : wait_on
    task apb(input logic w, input logic [11:0] ad, input logic [31:0] wd);
        @(posedge ref_clk_i);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= wd;
        @(posedge ref_clk_i);
        penable <= 1'b1;
        wait_on(2, 1'b1);
        rd = prdata_o;
        er = pslverr_o;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task send(input logic a, input logic [7:0] b);
        @(posedge ref_clk_i);
        atn <= a;
        dio_drv <= b;
        wait_on(0, 1'b1);
        dav <= 1'b1;
        wait_on(1, 1'b1);
        dav <= 1'b0;
        dio_drv <= ~b;
        wait_on(1, 1'b0);
        atn <= 1'b0;
    endtask : send
    task state(input logic [1:0] e);
        apb(1'b0, OFF_STATUS, 32'h0);
        cmp(rd[1:0], e);
    endtask : state
    task listen(input logic [7:0] b);
        send(1'b1, 8'h25);
        send(1'b0, b);
        send(1'b1, 8'h3F);
    endtask : listen
    task talk(input int n);
        u_gpib_far_side_model.rx_q.delete();
        send(1'b1, 8'h45);
        want = n;
        wait_on(3, 1'b1);
    endtask : talk
    initial begin
        {err_count, compares, want} = 0;
        {rst_i, ifc_i, atn, dav, stall, psel, penable, pwrite} = 8'h80;
        {paddr, pwdata, dio_drv} = 52'h0;
        {rsp_r, rsp_x, rsp_q} = {24'hA1B2C3, 2'h3};
        repeat (20) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        apb(1'b0, OFF_CFG, 32'h0);
        cmp(rd, 32'h0);
        apb(1'b1, OFF_CFG, 32'h5);
        apb(1'b0, 12'h020, 32'h0);
        cmp({rd[30:0], er}, 32'h1);
        send(1'b1, 8'h01);
        state(2'h0);
        send(1'b1, 8'h25);
        state(2'h2);
        for (int k = 0; k < 6; k++) begin
            send(1'b0, 8'(48'h510307123456 >> (40 - 8 * k)));
        end
        apb(1'b0, OFF_CMD, 32'h0);
        cmp(rd, 32'h11 | 32'h3 << 5 | 32'h7 << 9);
        apb(1'b0, OFF_WDATA, 32'h0);
        cmp(rd, 32'h563412);
        send(1'b1, 8'h3F);
        state(2'h0);
        send(1'b1, 8'h5F);
        state(2'h0);
        listen(8'h27);
        listen(8'h01);
        apb(1'b0, OFF_STATUS, 32'h0);
        cmp(rd[9:8], 2'h1);
        stall <= 1'b1;
        send(1'b1, 8'h45);
        repeat (400) @(posedge ref_clk_i);
        stall <= 1'b0;
        want = 3;
        wait_on(3, 1'b1);
        cmp(u_gpib_far_side_model.rx_q[0], 9'h0C3);
        cmp(u_gpib_far_side_model.rx_q[1], 9'h0B2);
        cmp(u_gpib_far_side_model.rx_q[2], 9'h103);
        cmp(s1at, 100);
        cmp(s1n, 50);
        cmp(s2at, 175);
        cmp(s2n, 50);
        cmp(blen, 250);
        cmp(ncyc, 1);
        cmp(snap, 18'h1CE71);
        cmp(snap_w, 24'h563412);
        cmp({f_o, c_o, i_o}, 7'h0);
        state(2'h1);
        apb(1'b0, OFF_CMD, 32'h0);
        cmp(rd[16:14], 3'h4);
        send(1'b1, 8'h5F);
        state(2'h0);
        send(1'b1, 8'h18);
        state(2'h3);
        talk(1);
        cmp(u_gpib_far_side_model.rx_q[0], 9'h103);
        cmp(ncyc, 1);
        send(1'b1, 8'h19);
        state(2'h0);
        listen(8'h06);
        rsp_q <= 1'b0;
        talk(2);
        cmp(u_gpib_far_side_model.rx_q[1], 9'h101);
        apb(1'b0, OFF_STATUS, 32'h0);
        cmp({rd[3], rd[9:8]}, 3'h2);
        send(1'b1, 8'h5F);
        send(1'b1, 8'h25);
        @(posedge ref_clk_i);
        ifc_i <= 1'b1;
        @(posedge ref_clk_i);
        ifc_i <= 1'b0;
        apb(1'b0, OFF_STATUS, 32'h0);
        cmp(rd, 32'h0);
        apb(1'b0, OFF_CFG, 32'h0);
        cmp(rd, 32'h5);
        complete_run();
    end
endmodule : gpib_camac_bridge_control_bench
